// ===== rtl/sgl_descriptor_decoder.sv
// Scatter-gather descriptor decoder with APB status and interrupt registers.
//
// Notes on behaviour
// RULE_01: Type 0h data block, 1h bit bucket.
// RULE_02: Type 2h segment, 3h last segment.
// RULE_03: Type 4h keyed; 5h-Eh reserved; Fh vendor.
// RULE_04: Sub-type 0h means absolute 64-bit address.
// RULE_05: Sub-type 1h offset; illegal on PCIe.
// RULE_06: Sub-types Ah-Fh go to transport logic.
// RULE_07: Address bytes 7-0, length 11-8, identifier 15.
// RULE_08: Identifier: sub-type low nibble, type high.
// RULE_09: Zero length data block is valid, no transfer.
// RULE_10: Address plus length overflow flags length error; the code checks this only on type 0h with a sub-type below Ah.
// RULE_11: Reserved or unsupported type flags error.
// RULE_12: Unsupported sub-type reports as type error.
// RULE_13: Misplaced segment pointer aborts the command.
// RULE_14: Outputs fields, one-cycle valid, error flag.
`timescale 1ns/1ps
module sgl_descriptor_decoder (
  input  wire logic                ref_clk_i,     // 10 MHz clock.
  input  wire logic                rstn_i,        // Asynchronous reset, active low.
  input  wire logic                desc_valid_i,  // Descriptor present this cycle.
  input  wire logic [127:0]        desc_i,        // Raw descriptor, byte 0 in bits 7..0.
  input  wire logic                desc_last_i,   // Last descriptor of its segment.
  input  wire logic                seg_final_i,   // Segment is the final segment.
  input  wire logic                desc_meta_i,   // Descriptor is from metadata list.
  input  wire logic                psel,          // APB select.
  input  wire logic                penable,       // APB enable.
  input  wire logic                pwrite,        // APB direction.
  input  wire logic [11:0]         paddr,         // APB byte address.
  input  wire logic [31:0]         pwdata,        // APB write data.
  output logic                     pready,        // APB ready.
  output logic [31:0]              prdata,        // APB read data.
  output logic                     pslverr,       // APB error.
  output sgl_pkg::desc_fields_t    out_fields_o,  // Parsed descriptor fields.
  output sgl_pkg::desc_flags_t     out_flags_o,   // Parsed descriptor flags.
  output logic                     out_valid_o,   // One-cycle strobe with fields.
  output logic                     out_error_o,   // Error with this descriptor.
  output logic                     irq_o          // Level interrupt.
);
  import sgl_pkg::*;

  // ----------------------------------------------------------------------------
  // Classification.
  // ----------------------------------------------------------------------------
  desc_fields_t fields_w;  // Combinational fields.
  desc_flags_t  flags_w;   // Combinational flags.
  logic         pcie_r;    // Transport select from the control register.

  sgl_classify u_classify (
    .desc_i    (desc_i),
    .last_i    (desc_last_i),
    .in_last_i (seg_final_i),
    .meta_i    (desc_meta_i),
    .pcie_i    (pcie_r),
    .fields_o  (fields_w),
    .flags_o   (flags_w)
  );

  // Any error condition of the current descriptor.
  wire logic err_w = flags_w.type_err || flags_w.len_err || flags_w.abort;

  // Events raised by a descriptor in this cycle.
  wire logic [NUM_EVENTS-1:0] ev_w = {NUM_EVENTS{desc_valid_i}} &
    {flags_w.abort, flags_w.len_err, flags_w.type_err, 1'b1};

  // ----------------------------------------------------------------------------
  // Output stage: fields and strobe register one cycle after input.
  // ----------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_fields_o <= '0;
      out_flags_o  <= '0;
      out_valid_o  <= 1'b0;
      out_error_o  <= 1'b0;
    end else begin
      out_valid_o <= desc_valid_i;                  // [RULE_14]
      out_error_o <= desc_valid_i && err_w;         // [RULE_14]
      if (desc_valid_i) begin
        out_fields_o <= fields_w;                   // [RULE_14]
        out_flags_o  <= flags_w;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------------------
  wire logic acc_w  = psel && penable;                     // Access phase.
  wire logic wr_w   = acc_w && pwrite;                     // Write taking effect.
  wire logic hit_ctrl  = (paddr == OFS_CTRL);
  wire logic hit_stat  = (paddr == OFS_STATUS);
  wire logic hit_clr   = (paddr == OFS_CLEAR);
  wire logic hit_en    = (paddr == OFS_ENABLE);
  wire logic hit_cnt   = (paddr == OFS_COUNT);
  wire logic mapped_w  = hit_ctrl || hit_stat || hit_clr || hit_en || hit_cnt;

  logic [NUM_EVENTS-1:0] status_r;  // Sticky event bits.
  logic [NUM_EVENTS-1:0] enable_r;  // Interrupt enables.
  logic [31:0]           count_r;   // Descriptors decoded.

  // Read mux; the clear register reads zero.
  wire logic [31:0] rdata_w =
    hit_ctrl ? {31'h0000_0000, pcie_r} :
    hit_stat ? {{(32-NUM_EVENTS){1'b0}}, status_r} :
    hit_en   ? {{(32-NUM_EVENTS){1'b0}}, enable_r} :
    hit_cnt  ? count_r : 32'h0000_0000;

  // ----------------------------------------------------------------------------
  // Registers. A set in the same cycle as a clear wins.
  // ----------------------------------------------------------------------------
  wire logic [NUM_EVENTS-1:0] clr_w = (wr_w && hit_clr) ? pwdata[NUM_EVENTS-1:0] : '0;
  wire logic [NUM_EVENTS-1:0] status_nxt = (status_r & ~clr_w) | ev_w;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pcie_r   <= CTRL_RESET[0];
      enable_r <= '0;
      status_r <= '0;
      count_r  <= 32'h0000_0000;
    end else begin
      status_r <= status_nxt;
      if (desc_valid_i) begin
        count_r <= count_r + 32'h0000_0001;
      end
      if (wr_w && hit_ctrl) begin
        pcie_r <= pwdata[0];                        // [RULE_05]
      end
      if (wr_w && hit_en) begin
        enable_r <= pwdata[NUM_EVENTS-1:0];
      end
    end
  end

  // Bus answer registered: ready in the first cycle of the access phase.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      irq_o   <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= rdata_w;
      pslverr <= psel && !penable && !mapped_w;
      irq_o   <= |(status_nxt & enable_r);
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  sequence s_desc_in;
    desc_valid_i;
  endsequence

  a_valid_strobe: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in |=> out_valid_o) else $error("valid strobe missing");  // [RULE_14]

  a_type_field: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in |=> out_fields_o.dtype == $past(desc_i[127:124]))
    else $error("type field wrong");  // [RULE_08]

  a_len_field: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in |=> out_fields_o.len == $past(desc_i[95:64]))
    else $error("length field wrong");  // [RULE_07]

  a_rsvd_type: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in and (desc_i[127:124] >= 4'h5) |=> out_error_o && out_flags_o.type_err)
    else $error("reserved type not flagged");  // [RULE_11]

  a_zero_len: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in and (desc_i[127:120] == 8'h00 && desc_i[95:64] == 32'h0000_0000)
    |=> !out_error_o && out_flags_o.no_xfer) else $error("zero length rejected");  // [RULE_09]

  a_pcie_offset: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in and (pcie_r && desc_i[127:120] == 8'h01) |=> out_flags_o.type_err)
    else $error("offset accepted on PCIe");  // [RULE_05]

  a_xport_sub: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in and (desc_i[123:120] >= 4'hA) |=> out_flags_o.xport && !out_flags_o.len_err)
    else $error("transport sub-type decoded");  // [RULE_06]

  a_ptr_abort: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in and (desc_i[127:125] == 3'h1 && !desc_last_i) |=> out_flags_o.abort ##1 status_r[3])
    else $error("misplaced pointer not aborted");  // [RULE_13]

  a_overflow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    s_desc_in and (desc_i[127:120] == 8'h00 && desc_i[63:0] == 64'hFFFF_FFFF_FFFF_FFFF &&
    desc_i[95:64] == 32'h0000_0002) |=> out_flags_o.len_err)
    else $error("overflow not flagged");  // [RULE_10]

endmodule

// ===== rtl/sgl_pkg.sv
// Package with descriptor field layouts, codes and register offsets for the descriptor decoder.
package sgl_pkg;

  // ----------------------------------------------------------------------------
  // Descriptor field positions (bit indices within the 128-bit descriptor).
  // ----------------------------------------------------------------------------
  localparam int ADDR_LSB   = 0;    // Address occupies bytes 7..0.
  localparam int LEN_LSB    = 64;   // Length occupies bytes 11..8.
  localparam int RSVD_LSB   = 96;   // Reserved bytes 14..12.
  localparam int SUB_LSB    = 120;  // Sub-type is bits 3..0 of byte 15.
  localparam int TYPE_LSB   = 124;  // Type is bits 7..4 of byte 15.

  // ----------------------------------------------------------------------------
  // Descriptor type codes.
  // ----------------------------------------------------------------------------
  localparam logic [3:0] TYPE_DATA     = 4'h0;  // Plain data block.
  localparam logic [3:0] TYPE_BUCKET   = 4'h1;  // Bit bucket, data discarded.
  localparam logic [3:0] TYPE_SEGMENT  = 4'h2;  // Pointer to a non-final segment.
  localparam logic [3:0] TYPE_LAST_SEG = 4'h3;  // Pointer to the final segment.
  localparam logic [3:0] TYPE_KEYED    = 4'h4;  // Keyed data block.
  localparam logic [3:0] TYPE_RSV_LO   = 4'h5;  // First reserved code.
  localparam logic [3:0] TYPE_RSV_HI   = 4'hE;  // Last reserved code.
  localparam logic [3:0] TYPE_VENDOR   = 4'hF;  // Vendor-defined code.

  // ----------------------------------------------------------------------------
  // Sub-type codes.
  // ----------------------------------------------------------------------------
  localparam logic [3:0] SUB_ADDRESS   = 4'h0;  // Absolute address.
  localparam logic [3:0] SUB_OFFSET    = 4'h1;  // Address is an offset.
  localparam logic [3:0] SUB_XPORT_LO  = 4'hA;  // First transport-specific code.

  // ----------------------------------------------------------------------------
  // APB register offsets (byte addresses) and reset values.
  // ----------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;  // Control: PCIe transport select.
  localparam logic [11:0] OFS_STATUS   = 12'h004;  // Sticky event status, read only.
  localparam logic [11:0] OFS_CLEAR    = 12'h008;  // Write one to clear status.
  localparam logic [11:0] OFS_ENABLE   = 12'h00C;  // Interrupt enable.
  localparam logic [11:0] OFS_COUNT    = 12'h010;  // Descriptors decoded, read only.
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;  // PCIe transport by default.
  localparam int          NUM_EVENTS   = 4;

  // Event bit positions in the status, clear and enable registers.
  localparam int EV_DONE  = 0;  // A descriptor was decoded.
  localparam int EV_TYPE  = 1;  // Type or sub-type error.
  localparam int EV_LEN   = 2;  // Length invalid error.
  localparam int EV_ABORT = 3;  // Misplaced segment pointer abort.

  // ----------------------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  dtype;  // Descriptor type.
    logic [3:0]  sub;    // Sub-type.
    logic [63:0] addr;   // Address or offset.
    logic [31:0] len;    // Byte length.
  } desc_fields_t;

  typedef struct packed {
    logic type_err;   // Reserved, vendor or unsupported type or sub-type.
    logic len_err;    // Address plus length overflows 64 bits.
    logic meta_err;   // Length error belongs to the metadata list.
    logic abort;      // Segment pointer not in the last slot, or in the final segment.
    logic xport;      // Sub-type handed to transport-specific logic.
    logic is_offset;  // Address is an offset.
    logic no_xfer;    // Zero length or bit bucket, no data moves.
  } desc_flags_t;

endpackage

// ===== rtl/sgl_classify.sv
// Combinational classifier that splits one descriptor into fields and flags.
`timescale 1ns/1ps
module sgl_classify (
  input  wire logic [127:0]        desc_i,      // Raw 16-byte descriptor.
  input  wire logic                last_i,      // Descriptor is last in its segment.
  input  wire logic                in_last_i,   // Segment is the final segment.
  input  wire logic                meta_i,      // Descriptor belongs to metadata list.
  input  wire logic                pcie_i,      // PCIe transport selected.
  output sgl_pkg::desc_fields_t    fields_o,    // Extracted fields.
  output sgl_pkg::desc_flags_t     flags_o      // Classification flags.
);
  import sgl_pkg::*;

  // ----------------------------------------------------------------------------
  // Field extraction.
  // ----------------------------------------------------------------------------
  wire logic [3:0]  dtype = desc_i[TYPE_LSB +: 4];  // Type nibble of byte 15. [RULE_08]
  wire logic [3:0]  sub   = desc_i[SUB_LSB +: 4];   // Sub-type nibble of byte 15. [RULE_08]
  wire logic [63:0] addr  = desc_i[ADDR_LSB +: 64]; // Bytes 7..0. [RULE_07]
  wire logic [31:0] len   = desc_i[LEN_LSB +: 32];  // Bytes 11..8; 14..12 ignored. [RULE_07]

  // Type classes.
  wire logic is_data   = (dtype == TYPE_DATA);                          // [RULE_01]
  wire logic is_bucket = (dtype == TYPE_BUCKET);                        // [RULE_01]
  wire logic is_ptr    = (dtype == TYPE_SEGMENT) ||
                         (dtype == TYPE_LAST_SEG);                      // [RULE_02]
  wire logic is_keyed  = (dtype == TYPE_KEYED);                         // [RULE_03]
  wire logic is_rsvd   = (dtype >= TYPE_RSV_LO) && (dtype <= TYPE_RSV_HI) ||
                         (dtype == TYPE_VENDOR);                        // [RULE_03]

  // Sub-type classes; offset is legal only off PCIe and on types 0h, 2h, 3h.
  wire logic sub_abs   = (sub == SUB_ADDRESS) && (is_data || is_ptr || is_keyed);   // [RULE_04]
  wire logic sub_ofs   = (sub == SUB_OFFSET) && (is_data || is_ptr) && !pcie_i;     // [RULE_05]
  wire logic sub_xport = (sub >= SUB_XPORT_LO);                                      // [RULE_06]
  wire logic sub_bad   = !sub_abs && !sub_ofs && !sub_xport && !is_bucket;           // [RULE_12]

  // Overflow: 65-bit sum above 2^64 marks an invalid length.
  wire logic [64:0] end_addr = {1'b0, addr} + {33'h0_0000_0000, len};
  wire logic        overflow = end_addr[64] && (end_addr[63:0] != 64'h0);           // [RULE_10]

  // ----------------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------------
  assign fields_o = '{dtype: dtype, sub: sub, addr: addr, len: len};
  assign flags_o.type_err  = is_rsvd || sub_bad;                                     // [RULE_11]
  assign flags_o.len_err   = is_data && !sub_xport && overflow;                      // [RULE_10]
  assign flags_o.meta_err  = is_data && !sub_xport && overflow && meta_i;            // [RULE_10]
  assign flags_o.abort     = is_ptr && (!last_i || in_last_i);                       // [RULE_13]
  assign flags_o.xport     = sub_xport;                                              // [RULE_06]
  assign flags_o.is_offset = sub_ofs;                                                // [RULE_05]
  assign flags_o.no_xfer   = (len == 32'h0000_0000) || is_bucket;                    // [RULE_09]

endmodule

// ===== verification/host_seg_model.sv
// Host memory model that streams one software-built descriptor segment.
`timescale 1ns/1ps
module host_seg_model (
  input  wire logic         clk_i,    // Controller clock.
  input  wire logic         rstn_i,   // Reset, active low.
  input  wire logic         start_i,  // Pulse that starts streaming the segment.
  input  wire logic [6:0]   count_i,  // Number of descriptors in the segment.
  output logic              valid_o,  // Descriptor present this cycle.
  output logic [127:0]      desc_o,   // Descriptor, byte n in bits 8n+7:8n.
  output logic              last_o    // Descriptor is the last of the segment.
);
  logic [127:0] mem [0:63];  // Segment image as software built it.
  logic [6:0]   idx_r;       // Next entry to send.
  logic         run_r;       // Streaming is in progress.
  // -----------------------------------------------------------------------
  // Streaming: entries go back to back, idle data toggles every cycle.
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_r   <= 1'b0;
      idx_r   <= 7'h00;
      valid_o <= 1'b0;
      desc_o  <= '0;
      last_o  <= 1'b0;
    end else if (run_r) begin
      valid_o <= 1'b1;
      desc_o  <= mem[idx_r];
      last_o  <= (idx_r == count_i - 7'h01);
      idx_r   <= idx_r + 7'h01;
      run_r   <= (idx_r != count_i - 7'h01);
    end else begin
      // Stale values must never look like a held descriptor.
      valid_o <= 1'b0;
      desc_o  <= ~desc_o;
      last_o  <= ~last_o;
      run_r   <= start_i;
      idx_r   <= 7'h00;
    end
  end
endmodule

// ===== verification/sgl_descriptor_decoder_tb.sv
// Self-checking testbench for the descriptor decoder and its registers.
`timescale 1ns/1ps
module sgl_descriptor_decoder_tb;
  import sgl_pkg::*;
  logic ref_clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, irq_o;
  logic dv, lst, fin, meta, start, out_valid_o, out_error_o, dv_q, er;
  logic [127:0] dsc;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [6:0]   cnt;
  desc_fields_t out_fields_o;
  desc_flags_t  out_flags_o;
  desc_fields_t ef [$];  // Expected fields, in order.
  desc_flags_t  eg [$];  // Expected flags, in order.
  int failures, comparisons;
  logic [3:0] subs [4] = '{4'h0, 4'h1, 4'hA, 4'h2};  // Sub-types tried per type.
  host_seg_model host (.clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start), .count_i(cnt),
    .valid_o(dv), .desc_o(dsc), .last_o(lst));
  sgl_descriptor_decoder dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .desc_valid_i(dv),
    .desc_i(dsc), .desc_last_i(lst), .seg_final_i(fin), .desc_meta_i(meta), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .out_fields_o(out_fields_o),
    .out_flags_o(out_flags_o), .out_valid_o(out_valid_o), .out_error_o(out_error_o),
    .irq_o(irq_o));
  // -----------------------------------------------------------------------
  // Helpers: comparison, verdict, bus cycle and expected classification.
  // -----------------------------------------------------------------------
  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge ref_clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      check("apb timeout", 1'b1, 1'b0);
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check("prdata", rd, e);
    check("pslverr", er, 1'b0);
  endtask
  function automatic desc_flags_t exp_flags(logic [127:0] d, logic l, logic f, logic m,
                                            logic pcie);
    desc_flags_t g;
    logic [3:0]  t, s;
    logic        ok;
    t = d[127:124];
    s = d[123:120];
    ok = (t == 4'h1) || (s >= 4'hA) || (s == 4'h0 && t inside {4'h0, 4'h2, 4'h3, 4'h4}) ||
         (s == 4'h1 && !pcie && t inside {4'h0, 4'h2, 4'h3});
    g = '0;
    g.type_err = (t >= 4'h5) || !ok;
    g.len_err  = (t == 4'h0) && (s < 4'hA) &&
                 ({1'b0, d[63:0]} + {33'h0, d[95:64]} > 65'h1_0000_0000_0000_0000);
    g.meta_err = g.len_err && m;
    g.abort    = (t == 4'h2 || t == 4'h3) && (!l || f);
    g.xport    = (s >= 4'hA);
    g.is_offset = (s == 4'h1) && !pcie && (t inside {4'h0, 4'h2, 4'h3});
    g.no_xfer  = (d[95:64] == 32'h0000_0000) || (t == 4'h1);
    return g;
  endfunction
  // Streams n loaded entries and waits until every one has been answered.
  task automatic run(input int n, input logic f, input logic m, input logic pcie);
    int k;
    for (k = 0; k < n; k++) begin
      ef.push_back({host.mem[k][127:120], host.mem[k][63:0], host.mem[k][95:64]});
      eg.push_back(exp_flags(host.mem[k], k == n - 1, f, m, pcie));
    end
    fin <= f; meta <= m; cnt <= 7'(n);
    @(posedge ref_clk_i) start <= 1'b1;
    @(posedge ref_clk_i) start <= 1'b0;
    k = 0;
    while (ef.size() != 0 && k < 300) begin
      @(posedge ref_clk_i);
      k++;
    end
    if (k >= 300) begin
      check("descriptor timeout", 1'b1, 1'b0);
      results();
    end
  endtask
  // -----------------------------------------------------------------------
  // Monitor: every strobe follows its descriptor by exactly one cycle.
  // -----------------------------------------------------------------------
  always @(posedge ref_clk_i) dv_q <= dv;
  always @(posedge ref_clk_i) begin
    if (out_valid_o === 1'b1 && ef.size() == 0) begin
      check("spurious valid", 1'b1, 1'b0);
    end else if (out_valid_o === 1'b1) begin
      check("latency", dv_q, 1'b1);
      check("fields", out_fields_o, ef.pop_front());
      check("error", out_error_o, eg[0].type_err | eg[0].len_err | eg[0].abort);
      check("flags", out_flags_o, eg.pop_front());
    end
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // -----------------------------------------------------------------------
  // Main sequence.
  // -----------------------------------------------------------------------
  initial begin
    rstn_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; fin = 1'b0; meta = 1'b0; start = 1'b0; cnt = 7'h00;
    failures = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd_chk(OFS_CTRL, CTRL_RESET);
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_ENABLE, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0000_0000);
    // Every type with four sub-types; pointers mid-segment must abort.
    for (int i = 0; i < 64; i++) host.mem[i] = {4'(i / 4), subs[i % 4], 24'h0, 32'h10, 64'(i)};
    run(64, 1'b0, 1'b0, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    run(64, 1'b1, 1'b1, 1'b0);
    // Length limit, zero length and a last-segment pointer in the last slot.
    host.mem[0] = {8'h00, 24'h0, 32'h100, 64'hFFFF_FFFF_FFFF_FF00};
    host.mem[1] = {8'h00, 24'h0, 32'h101, 64'hFFFF_FFFF_FFFF_FF00};
    host.mem[2] = 128'h0;
    host.mem[3] = {8'h00, 24'h0, 32'h2, 64'hFFFF_FFFF_FFFF_FFFF};
    host.mem[4] = {8'h30, 24'h0, 32'h8, 64'h1000};
    run(5, 1'b0, 1'b1, 1'b0);
    check("irq masked", irq_o, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_000F);
    rd_chk(OFS_COUNT, 32'h0000_0085);
    apb(1'b1, OFS_ENABLE, 32'h0000_0004);
    // The interrupt register sees the new enable one edge after the write lands.
    repeat (2) @(posedge ref_clk_i);
    check("irq raised", irq_o, 1'b1);
    apb(1'b1, OFS_CLEAR, 32'h0000_0004);
    apb(1'b1, OFS_STATUS, 32'h0000_0000);
    @(posedge ref_clk_i);
    check("irq cleared", irq_o, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000_000B);
    rd_chk(OFS_CLEAR, 32'h0000_0000);
    rd_chk(OFS_ENABLE, 32'h0000_0004);
    results();
  end
endmodule
